// ===== hdl/dev_sig_pkg.sv
// Functional notes
// - Non-packet unit loads signature after every reset and the self-diagnose command.
// - Non-packet signature: count 01h, low 01h, mid 00h, high 00h.
// - Packet unit also loads signature after the targeted soft restart command.
// - Targeted soft restart keeps the unit select bit unchanged.
// - Packet unit answers capability query and block read with the signature.
// - Packet signature: reason 01h, low 01h, length low 14h, high EBh.
// - Packet signature stays unchanged until a command sets the ready flag.
// - Host write to a signature register replaces it and invalidates the signature.
// - Patterns 3Ch/C3h and 69h/96h are reserved and carry no meaning.
// - Lone primary, secondary selected: control register writes still take effect.
// - Lone primary: command block writes except command still take effect.
// - Lone primary: command writes ignored except the self-diagnose command.
// - Lone non-packet primary reads normally, but status reads return 00h.
// - Lone packet primary returns 00h for every task file register read; config and state still read normally.
// - Lone secondary behaves exactly as if the primary unit were present.
// - Parameters are loaded first; the command code write triggers the command.
// - A failing command presents its error output register contents.
// - Status is read only; writes to its address reach the command register.
package dev_sig_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_ERRFEAT    = 8'h00;
  localparam logic [7:0] OFS_COUNT      = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW   = 8'h08;
  localparam logic [7:0] OFS_ADDR_MID   = 8'h0c;
  localparam logic [7:0] OFS_ADDR_HIGH  = 8'h10;
  localparam logic [7:0] OFS_UNIT_SEL   = 8'h14;
  localparam logic [7:0] OFS_STATUS_CMD = 8'h18;
  localparam logic [7:0] OFS_ALT_CTRL   = 8'h1c;
  localparam logic [7:0] OFS_CONFIG     = 8'h20;
  localparam logic [7:0] OFS_STATE      = 8'h24;
  // ==========================================================================
  // Signature values
  localparam logic [7:0] SIG_COUNT      = 8'h01;
  localparam logic [7:0] SIG_LOW        = 8'h01;
  localparam logic [7:0] SIG_ATA_MID    = 8'h00;
  localparam logic [7:0] SIG_ATA_HIGH   = 8'h00;
  localparam logic [7:0] SIG_PKT_MID    = 8'h14;
  localparam logic [7:0] SIG_PKT_HIGH   = 8'heb;
  // ==========================================================================
  // Command codes and error codes
  localparam logic [7:0] CMD_DIAG       = 8'h90;
  localparam logic [7:0] CMD_DEV_RESET  = 8'h08;
  localparam logic [7:0] CMD_CAP_QUERY  = 8'hec;
  localparam logic [7:0] CMD_READ       = 8'h20;
  localparam logic [7:0] CMD_READ_NR    = 8'h21;
  localparam logic [7:0] ERR_ABORT      = 8'h04;
  localparam logic [7:0] DIAG_PASS      = 8'h01;
  // ==========================================================================
  // Field positions and reset values
  localparam int         UNIT_BIT       = 4;
  localparam int         CTL_SRST       = 2;
  localparam int         CFG_PACKET     = 0;
  localparam int         CFG_UNIT       = 1;
  localparam int         CFG_LONE       = 2;
  localparam logic [2:0] CFG_RESET      = 3'h0;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  // ==========================================================================
  // Command phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_EXEC = 2'b01,
    PH_SRST = 2'b10
  } phase_t;
endpackage

// ===== hdl/task_file_if.sv
`timescale 1ns/1ps
interface task_file_if;
  logic        wrEn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;
  modport port (output wrEn, output addr, output wdata, input rdata, input hit);
  modport core (input wrEn, input addr, input wdata, output rdata, output hit);
endinterface // task_file_if

// ===== hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= RESET_VALUE;
      dout   <= RESET_VALUE;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // pin_sync

// ===== hdl/apb_access_port.sv
`timescale 1ns/1ps
module apb_access_port (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side
  task_file_if.port        bus
);
  // One wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !bus.hit;
      prdata  <= (!pwrite && bus.hit) ? bus.rdata : 32'h0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Write takes effect at the edge that completes the transfer
  assign bus.wrEn  = psel && penable && pready && pwrite && bus.hit;
  assign bus.addr  = paddr;
  assign bus.wdata = pwdata;
endmodule // apb_access_port

// ===== hdl/device_signature_select.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module device_signature_select (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Hardware reset pin, active low
  input  wire logic        hwResetN,
  // Command back end
  output logic             cmdStart,
  output logic [7:0]       cmdCode,
  input  wire logic        cmdDone,
  input  wire logic        cmdFailed,
  input  wire logic [7:0]  failError,
  input  wire logic [7:0]  failCount,
  input  wire logic [7:0]  failLow,
  input  wire logic [7:0]  failMid,
  input  wire logic [7:0]  failHigh
);
  // ==========================================================================
  // Declarations
  task_file_if        bus ();
  dev_sig_pkg::phase_t phase;
  logic               hwResetSync;
  logic               hwActive;
  logic [7:0]         feature;
  logic [7:0]         count;
  logic [7:0]         addrLow;
  logic [7:0]         addrMid;
  logic [7:0]         addrHigh;
  logic [7:0]         unitSel;
  logic [7:0]         errorReg;
  logic [7:0]         devCtl;
  logic [2:0]         cfg;
  logic               ready;
  logic               errFlag;
  logic               sigValid;
  logic               sigPending;
  logic               busy;
  logic               cfgPacket;
  logic               cfgUnit;
  logic               lonePrimary;
  logic               selected;
  logic [7:0]         wd;
  logic               cmdWrite;
  logic               cmdTake;
  logic               doDiag;
  logic               doDevReset;
  logic               doAbortSig;
  logic               doForward;
  logic               srstSet;
  logic               srstRelease;
  logic               loadSig;
  logic               keepUnit;
  logic               execDone;
  logic               sigWrite;
  logic [7:0]         status;
  logic [7:0]         normal;
  logic               taskFileAddr;

  // ==========================================================================
  // Bus port and pin synchroniser
  apb_access_port u_port (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus.port)
  );

  // Pin idles high; flops reset high so no false reset follows sys_rst
  pin_sync #(
    .RESET_VALUE (1'b1)
  ) u_hw_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .din     (hwResetN),
    .dout    (hwResetSync)
  );

  // ==========================================================================
  // Event decode
  assign hwActive    = !hwResetSync;
  assign wd          = bus.wdata[7:0];
  assign cfgPacket   = cfg[dev_sig_pkg::CFG_PACKET];
  assign cfgUnit     = cfg[dev_sig_pkg::CFG_UNIT];
  assign lonePrimary = cfg[dev_sig_pkg::CFG_LONE] && !cfgUnit;
  assign busy        = (phase != dev_sig_pkg::PH_IDLE);
  // Selection by unit number; a lone secondary sees no difference either way
  assign selected    = (unitSel[dev_sig_pkg::UNIT_BIT] == cfgUnit);

  // The status address takes command writes; writing the code starts it
  assign cmdWrite = bus.wrEn && (bus.addr == dev_sig_pkg::OFS_STATUS_CMD);
  // Unselected unit drops commands but still runs self-diagnose
  assign cmdTake  = cmdWrite && !hwActive && (phase == dev_sig_pkg::PH_IDLE)
                    && (selected || (wd == dev_sig_pkg::CMD_DIAG));
  assign doDiag   = cmdTake && (wd == dev_sig_pkg::CMD_DIAG);
  // Targeted soft restart is honoured even while a command runs
  assign doDevReset = cmdWrite && !hwActive && selected && cfgPacket
                      && (phase != dev_sig_pkg::PH_SRST)
                      && (wd == dev_sig_pkg::CMD_DEV_RESET);
  assign doAbortSig = cmdTake && cfgPacket
                      && ((wd == dev_sig_pkg::CMD_CAP_QUERY)
                          || (wd == dev_sig_pkg::CMD_READ)
                          || (wd == dev_sig_pkg::CMD_READ_NR));
  assign doForward  = cmdTake && !doDiag && !doAbortSig
                      && !(cfgPacket && (wd == dev_sig_pkg::CMD_DEV_RESET));

  assign srstSet     = bus.wrEn && (bus.addr == dev_sig_pkg::OFS_ALT_CTRL)
                       && wd[dev_sig_pkg::CTL_SRST];
  assign srstRelease = bus.wrEn && (bus.addr == dev_sig_pkg::OFS_ALT_CTRL)
                       && !wd[dev_sig_pkg::CTL_SRST] && (phase == dev_sig_pkg::PH_SRST);

  // Every reset kind, self-diagnose and the packet commands reload the signature
  assign loadSig  = sigPending || srstRelease || doDiag || doDevReset
                    || doAbortSig;
  assign keepUnit = doDevReset || doAbortSig;
  assign execDone = (phase == dev_sig_pkg::PH_EXEC) && cmdDone;
  assign sigWrite = bus.wrEn && ((bus.addr == dev_sig_pkg::OFS_COUNT)
                    || (bus.addr == dev_sig_pkg::OFS_ADDR_LOW)
                    || (bus.addr == dev_sig_pkg::OFS_ADDR_MID)
                    || (bus.addr == dev_sig_pkg::OFS_ADDR_HIGH));

  // ==========================================================================
  // Reset bookkeeping
  // Requests one more load in the cycle after the synchronised reset pin is released
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sigPending <= 1'b1;
    end else begin
      sigPending <= hwActive;
    end
  end

  // ==========================================================================
  // Command phase
  // Software reset overrides any running command; its late result is dropped
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= dev_sig_pkg::PH_IDLE;
    end else if (hwActive) begin
      phase <= dev_sig_pkg::PH_IDLE;
    end else if (srstSet) begin
      phase <= dev_sig_pkg::PH_SRST;
    end else begin
      case (phase)
        dev_sig_pkg::PH_IDLE: begin
          if (doForward) begin
            phase <= dev_sig_pkg::PH_EXEC;
          end
        end
        dev_sig_pkg::PH_EXEC: begin
          if (doDevReset || cmdDone) begin
            phase <= dev_sig_pkg::PH_IDLE;
          end
        end
        dev_sig_pkg::PH_SRST: begin
          if (srstRelease) begin
            phase <= dev_sig_pkg::PH_IDLE;
          end
        end
        default: begin
          phase <= dev_sig_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Status flags
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready   <= 1'b0;
      errFlag <= 1'b0;
    end else if (hwActive || srstSet) begin
      ready   <= 1'b0;
      errFlag <= 1'b0;
    end else if (loadSig) begin
      // Packet unit stays not-ready after resets, diagnose and soft restart
      ready   <= !cfgPacket || doAbortSig;
      errFlag <= doAbortSig;
    end else if (doForward) begin
      errFlag <= 1'b0;
    end else if (execDone) begin
      ready   <= 1'b1;
      errFlag <= cmdFailed;
    end
  end

  // ==========================================================================
  // Task file bytes
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      feature  <= dev_sig_pkg::BYTE_RESET;
      count    <= dev_sig_pkg::BYTE_RESET;
      addrLow  <= dev_sig_pkg::BYTE_RESET;
      addrMid  <= dev_sig_pkg::BYTE_RESET;
      addrHigh <= dev_sig_pkg::BYTE_RESET;
      unitSel  <= dev_sig_pkg::BYTE_RESET;
      errorReg <= dev_sig_pkg::BYTE_RESET;
    end else if (loadSig) begin
      count    <= dev_sig_pkg::SIG_COUNT;
      addrLow  <= dev_sig_pkg::SIG_LOW;
      // Only the two defined patterns are produced, never the reserved ones
      addrMid  <= cfgPacket ? dev_sig_pkg::SIG_PKT_MID : dev_sig_pkg::SIG_ATA_MID;
      addrHigh <= cfgPacket ? dev_sig_pkg::SIG_PKT_HIGH : dev_sig_pkg::SIG_ATA_HIGH;
      errorReg <= doAbortSig ? dev_sig_pkg::ERR_ABORT : dev_sig_pkg::DIAG_PASS;
      if (!keepUnit) begin
        unitSel <= dev_sig_pkg::BYTE_RESET;
      end
    end else if (execDone && cmdFailed) begin
      // Failing command leaves its error output contents
      errorReg <= failError;
      count    <= failCount;
      addrLow  <= failLow;
      addrMid  <= failMid;
      addrHigh <= failHigh;
    end else if (bus.wrEn) begin
      // Host writes land whichever unit is selected
      case (bus.addr)
        dev_sig_pkg::OFS_ERRFEAT:   feature  <= wd;
        dev_sig_pkg::OFS_COUNT:     count    <= wd;
        dev_sig_pkg::OFS_ADDR_LOW:  addrLow  <= wd;
        dev_sig_pkg::OFS_ADDR_MID:  addrMid  <= wd;
        dev_sig_pkg::OFS_ADDR_HIGH: addrHigh <= wd;
        dev_sig_pkg::OFS_UNIT_SEL:  unitSel  <= wd;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Signature validity
  // A load wins over a host write landing in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sigValid <= 1'b0;
    end else if (loadSig) begin
      sigValid <= 1'b1;
    end else if (sigWrite || (execDone && cmdFailed)) begin
      sigValid <= 1'b0;
    end
  end

  // ==========================================================================
  // Device control and configuration
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      devCtl <= dev_sig_pkg::BYTE_RESET;
    end else if (hwActive) begin
      devCtl <= dev_sig_pkg::BYTE_RESET;
    end else if (bus.wrEn && (bus.addr == dev_sig_pkg::OFS_ALT_CTRL)) begin
      devCtl <= wd;
    end
  end

  // Configuration survives the reset pin; only sys_rst clears it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= dev_sig_pkg::CFG_RESET;
    end else if (bus.wrEn && (bus.addr == dev_sig_pkg::OFS_CONFIG)) begin
      cfg <= wd[2:0];
    end
  end

  // ==========================================================================
  // Back end command issue
  // Code holds the last forwarded command until the next one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdStart <= 1'b0;
      cmdCode  <= dev_sig_pkg::BYTE_RESET;
    end else begin
      cmdStart <= doForward;
      if (doForward) begin
        cmdCode <= wd;
      end
    end
  end

  // ==========================================================================
  // Read path
  // Config and state answer for either unit; task file reads follow selection
  assign status = {busy, ready, 5'b00000, errFlag};

  always_comb begin
    normal       = 8'h00;
    taskFileAddr = 1'b1;
    bus.hit      = 1'b1;
    case (bus.addr)
      dev_sig_pkg::OFS_ERRFEAT:    normal = errorReg;
      dev_sig_pkg::OFS_COUNT:      normal = count;
      dev_sig_pkg::OFS_ADDR_LOW:   normal = addrLow;
      dev_sig_pkg::OFS_ADDR_MID:   normal = addrMid;
      dev_sig_pkg::OFS_ADDR_HIGH:  normal = addrHigh;
      dev_sig_pkg::OFS_UNIT_SEL:   normal = unitSel;
      dev_sig_pkg::OFS_STATUS_CMD: normal = status;
      dev_sig_pkg::OFS_ALT_CTRL:   normal = status;
      dev_sig_pkg::OFS_CONFIG: begin
        normal       = {5'b00000, cfg};
        taskFileAddr = 1'b0;
      end
      dev_sig_pkg::OFS_STATE: begin
        normal       = {5'b00000, selected, busy, sigValid};
        taskFileAddr = 1'b0;
      end
      default: begin
        bus.hit      = 1'b0;
        taskFileAddr = 1'b0;
      end
    endcase
  end

  // Unselected units read zero from the task file unless the lone primary rules say otherwise
  always_comb begin
    bus.rdata = 32'h0;
    if (!taskFileAddr || selected) begin
      bus.rdata = {24'h0, normal};
    end else if (lonePrimary && !cfgPacket
                 && (bus.addr != dev_sig_pkg::OFS_STATUS_CMD)
                 && (bus.addr != dev_sig_pkg::OFS_ALT_CTRL)) begin
      bus.rdata = {24'h0, normal};
    end else begin
      // Packet lone primary, status reads and unselected units give zero
      bus.rdata = 32'h0;
    end
  end
endmodule // device_signature_select

// ===== test/device_signature_select_chk.sv
`timescale 1ns/1ps
module device_signature_select_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Bus and command side
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmdStart,
  input wire logic [7:0]  cmdCode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Bus timing
  property p_wait;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("pready not on third cycle");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_idle;
    !(psel && penable) |=> !pready;
  endproperty
  a_idle: assert property (p_idle) else $error("pready outside access");
  property p_err;
    pslverr |-> pready && (paddr > 8'h24 || paddr[1:0] != 2'b00);
  endproperty
  a_err: assert property (p_err) else $error("pslverr on mapped address");
  property p_map;
    pready && (paddr > 8'h24 || paddr[1:0] != 2'b00) |-> pslverr;
  endproperty
  a_map: assert property (p_map) else $error("unmapped address accepted");
  property p_upper;
    pready && !pwrite |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0);
  endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  // ==========================================================================
  // Command hand-off
  property p_cmd_pulse;
    cmdStart |=> !cmdStart;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("cmdStart too long");
  property p_cmd_src;
    cmdStart |-> $past(psel && penable && pready && pwrite
      && paddr == dev_sig_pkg::OFS_STATUS_CMD) && cmdCode == $past(pwdata[7:0]);
  endproperty
  a_cmd_src: assert property (p_cmd_src) else $error("cmdStart without write");
  property p_code;
    $changed(cmdCode) |-> cmdStart;
  endproperty
  a_code: assert property (p_code) else $error("cmdCode changed alone");
endmodule // device_signature_select_chk

bind device_signature_select device_signature_select_chk u_device_signature_select_chk (
  .sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .cmdStart, .cmdCode
);

// ===== test/cmd_back_end_model.sv
`timescale 1ns/1ps
module cmd_back_end_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Command side
  input  wire logic cmdStart,
  input  wire logic slow,
  input  wire logic failReq,
  output logic      cmdDone,
  output logic      cmdFailed,
  output logic [7:0] failError,
  output logic [7:0] failCount,
  output logic [7:0] failLow,
  output logic [7:0] failMid,
  output logic [7:0] failHigh
);
  logic [3:0] waitCnt;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt <= 4'h0;
      cmdDone <= 1'b0;
    end else begin
      cmdDone <= (waitCnt == 4'h1);
      if (cmdStart) begin
        waitCnt <= slow ? 4'h6 : 4'h1;
      end else if (waitCnt != 4'h0) begin
        waitCnt <= waitCnt - 4'h1;
      end
    end
  end
  // Result lines carry meaning only beside cmdDone; otherwise the inverse
  assign cmdFailed = cmdDone ? failReq : ~failReq;
  assign failError = cmdDone ? 8'h04 : 8'hfb;
  assign failCount = cmdDone ? 8'h14 : 8'heb;
  assign failLow   = cmdDone ? 8'h24 : 8'hdb;
  assign failMid   = cmdDone ? 8'h34 : 8'hcb;
  assign failHigh  = cmdDone ? 8'h44 : 8'hbb;
endmodule // cmd_back_end_model

// ===== test/test_device_signature_select.sv
`timescale 1ns/1ps
module test_device_signature_select;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        hwResetN = 1'b1;
  logic        slow = 1'b0;
  logic        failReq = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, cmdStart, cmdDone, cmdFailed, err;
  logic [7:0]  cmdCode, failError, failCount, failLow, failMid, failHigh;
  logic [7:0]  codes [3] = '{dev_sig_pkg::CMD_CAP_QUERY, dev_sig_pkg::CMD_READ,
                             dev_sig_pkg::CMD_READ_NR};
  int          n_errors = 0;
  int          checked = 0;
  int          nStarts = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (cmdStart === 1'b1) nStarts <= nStarts + 1;
  device_signature_select u_device_signature_select (.sys_clk, .sys_rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .hwResetN, .cmdStart,
    .cmdCode, .cmdDone, .cmdFailed, .failError, .failCount, .failLow, .failMid, .failHigh);
  cmd_back_end_model u_cmd_back_end_model (.sys_clk, .sys_rst, .cmdStart, .slow, .failReq,
    .cmdDone, .cmdFailed, .failError, .failCount, .failLow, .failMid, .failHigh);
  // ==========================================================================
  // Tasks
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("register %h", a), rd, {24'h0, e});
  endtask
  task automatic sig(input logic [7:0] m, input logic [7:0] h);
    rc(dev_sig_pkg::OFS_COUNT, 8'h01);
    rc(dev_sig_pkg::OFS_ADDR_LOW, 8'h01);
    rc(dev_sig_pkg::OFS_ADDR_MID, m);
    rc(dev_sig_pkg::OFS_ADDR_HIGH, h);
  endtask
  task automatic idle();
    int n = 0;
    do begin
      apb(1'b0, dev_sig_pkg::OFS_STATUS_CMD, 32'h0);
      n++;
    end while (rd[7] !== 1'b0 && n < 20);
    if (rd[7] !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    sig(8'h00, 8'h00);
    rc(dev_sig_pkg::OFS_STATE, 8'h05);
    wr(dev_sig_pkg::OFS_COUNT, 8'h55);
    rc(dev_sig_pkg::OFS_COUNT, 8'h55);
    rc(dev_sig_pkg::OFS_STATE, 8'h04);
    wr(dev_sig_pkg::OFS_STATUS_CMD, dev_sig_pkg::CMD_DIAG);
    sig(8'h00, 8'h00);
    rc(dev_sig_pkg::OFS_ERRFEAT, 8'h01);
    wr(dev_sig_pkg::OFS_ADDR_LOW, 8'h77);
    hwResetN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    hwResetN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sig(8'h00, 8'h00);
    wr(dev_sig_pkg::OFS_COUNT, 8'h66);
    wr(dev_sig_pkg::OFS_ALT_CTRL, 8'h04);
    wr(dev_sig_pkg::OFS_ALT_CTRL, 8'h00);
    sig(8'h00, 8'h00);
    slow <= 1'b1;
    wr(dev_sig_pkg::OFS_ADDR_LOW, 8'h12);
    wr(dev_sig_pkg::OFS_STATUS_CMD, 8'hc0);
    rc(dev_sig_pkg::OFS_STATE, 8'h06);
    check("command code", {24'h0, cmdCode}, 32'h000000c0);
    idle();
    rc(dev_sig_pkg::OFS_STATUS_CMD, 8'h40);
    rc(dev_sig_pkg::OFS_ADDR_LOW, 8'h12);
    failReq <= 1'b1;
    slow <= 1'b0;
    wr(dev_sig_pkg::OFS_STATUS_CMD, 8'hc0);
    idle();
    for (int i = 0; i < 5; i++) rc(8'(4 * i), {i[3:0], 4'h4});
    rc(dev_sig_pkg::OFS_STATUS_CMD, 8'h41);
    failReq <= 1'b0;
    wr(dev_sig_pkg::OFS_CONFIG, 8'h03);
    wr(dev_sig_pkg::OFS_UNIT_SEL, 8'h10);
    wr(dev_sig_pkg::OFS_COUNT, 8'h99);
    wr(dev_sig_pkg::OFS_STATUS_CMD, dev_sig_pkg::CMD_DEV_RESET);
    sig(8'h14, 8'heb);
    rc(dev_sig_pkg::OFS_UNIT_SEL, 8'h10);
    repeat (20) @(posedge sys_clk);
    sig(8'h14, 8'heb);
    for (int i = 0; i < 3; i++) begin
      wr(dev_sig_pkg::OFS_COUNT, 8'h99);
      wr(dev_sig_pkg::OFS_STATUS_CMD, codes[i]);
      sig(8'h14, 8'heb);
      rc(dev_sig_pkg::OFS_ERRFEAT, 8'h04);
    end
    wr(dev_sig_pkg::OFS_CONFIG, 8'h04);
    wr(dev_sig_pkg::OFS_UNIT_SEL, 8'h10);
    wr(dev_sig_pkg::OFS_COUNT, 8'h33);
    rc(dev_sig_pkg::OFS_COUNT, 8'h33);
    rc(dev_sig_pkg::OFS_STATUS_CMD, 8'h00);
    rc(dev_sig_pkg::OFS_ALT_CTRL, 8'h00);
    wr(dev_sig_pkg::OFS_STATUS_CMD, 8'hc0);
    @(posedge sys_clk);
    check("command starts", 32'(nStarts), 32'h2);
    wr(dev_sig_pkg::OFS_ALT_CTRL, 8'h04);
    wr(dev_sig_pkg::OFS_ALT_CTRL, 8'h00);
    rc(dev_sig_pkg::OFS_UNIT_SEL, 8'h00);
    wr(dev_sig_pkg::OFS_UNIT_SEL, 8'h10);
    wr(dev_sig_pkg::OFS_COUNT, 8'h33);
    wr(dev_sig_pkg::OFS_STATUS_CMD, dev_sig_pkg::CMD_DIAG);
    sig(8'h00, 8'h00);
    wr(dev_sig_pkg::OFS_CONFIG, 8'h05);
    wr(dev_sig_pkg::OFS_UNIT_SEL, 8'h10);
    for (int i = 0; i < 8; i++) rc(8'(4 * i), 8'h00);
    wr(dev_sig_pkg::OFS_CONFIG, 8'h06);
    wr(dev_sig_pkg::OFS_UNIT_SEL, 8'h00);
    rc(dev_sig_pkg::OFS_COUNT, 8'h00);
    wr(dev_sig_pkg::OFS_STATUS_CMD, dev_sig_pkg::CMD_DIAG);
    wr(dev_sig_pkg::OFS_UNIT_SEL, 8'h10);
    wr(dev_sig_pkg::OFS_COUNT, 8'h5a);
    rc(dev_sig_pkg::OFS_COUNT, 8'h5a);
    rc(dev_sig_pkg::OFS_STATUS_CMD, 8'h40);
    rc(dev_sig_pkg::OFS_ERRFEAT, 8'h01);
    rc(dev_sig_pkg::OFS_STATE, 8'h04);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    end_of_test();
  end
endmodule // test_device_signature_select
